/* graphics_dram_pin_interface.sv */
`timescale 1ns/1ps
// Contract
// - Commands and address sampled on rising clock
// - Read data launched on both clock edges
// - Clock enable high keeps device active
// - Enable low picks power-down or self refresh
// - Power transitions sampled on the clock
// - Self refresh exit by enable alone; here enable clears the flag at once, the state returns on the next clock rise
// - Power-down ignores all but clock, enable; termination pin still obeyed
// - Self refresh ignores all but enable; termination pin still obeyed
// - Chip select high masks the command
// - Command from select, row, column, write
// - Registered termination pin switches termination on
// - Termination on data, strobes, masks only
// - Termination pin ignored when mode disables
// - Masked write bytes are not stored
// - Masks sampled on both strobe edges
// - Bank inputs pick one of four
// - Bank bit zero selects mode register
// - Address ten picks single or all
// - Address carries row, column, op-code
// - Read strobe edge-aligned, write strobe centred
// - Lower strobe bytes 0-7, upper 8-15
// - One extended bit gates complementary strobes
// - Decode 13 row, 9 column, 2 bank; only row bit 0 and column bits 3:2 reach the store here
module graphics_dram_pin_interface (
	input  wire logic                                 clk,
	input  wire logic                                 sys_rst,
	input  wire logic                                 ck,
	input  wire logic                                 cke,
	input  wire dram_pin_pkg::cmd_pins_t              cmd_pins,
	input  wire logic                                 odt,
	input  wire logic [dram_pin_pkg::DQ_BITS-1:0]     dq_i,
	output logic      [dram_pin_pkg::DQ_BITS-1:0]     dq_o,
	output logic                                      dq_oe,
	input  wire logic [dram_pin_pkg::LANES-1:0]       byte_strobe_i,
	output logic      [dram_pin_pkg::LANES-1:0]       byte_strobe_o,
	output logic      [dram_pin_pkg::LANES-1:0]       byte_strobe_oe,
	input  wire logic [dram_pin_pkg::LANES-1:0]       byte_strobe_n_i,
	output logic      [dram_pin_pkg::LANES-1:0]       byte_strobe_n_o,
	output logic      [dram_pin_pkg::LANES-1:0]       byte_strobe_n_oe,
	input  wire logic                                 lower_byte_write_mask,
	input  wire logic                                 upper_byte_write_mask,
	output dram_pin_pkg::term_t                       term_en,
	output dram_pin_pkg::mode_regs_t                  mode_regs,
	output dram_pin_pkg::status_t                     status
);

	// ------------------------------------------------------------------
	// Reset into the link domain
	// ------------------------------------------------------------------
	logic rst_meta_q;  // First stage, read only by the second
	logic rst_link_q;  // Link-domain synchronous reset

	// Two stages; the link clock must run while reset is held
	always_ff @(posedge ck) begin
		rst_meta_q <= sys_rst;
		rst_link_q <= rst_meta_q;
	end

	// ------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------
	// Select high masks everything; otherwise the three strobes decide
	function automatic dram_pin_pkg::cmd_t decode_cmd(
		input dram_pin_pkg::cmd_pins_t p
	);
		dram_pin_pkg::cmd_t c;
		c = dram_pin_pkg::CMD_NOP;
		if (p.cs_n) begin
			c = dram_pin_pkg::CMD_DESEL;
		end else begin
			case ({p.ras_n, p.cas_n, p.we_n})
				3'h0:    c = dram_pin_pkg::CMD_MRS;
				3'h1:    c = dram_pin_pkg::CMD_REF;
				3'h2:    c = dram_pin_pkg::CMD_PRE;
				3'h3:    c = dram_pin_pkg::CMD_ACT;
				3'h4:    c = dram_pin_pkg::CMD_WR;
				3'h5:    c = dram_pin_pkg::CMD_RD;
				default: c = dram_pin_pkg::CMD_NOP;
			endcase
		end
		return c;
	endfunction

	// Store slot from bank, stored row bit and column group
	function automatic logic [dram_pin_pkg::BASE_BITS-1:0] store_base(
		input logic [dram_pin_pkg::BANK_BITS-1:0] ba,
		input logic                               row_bit,
		input logic [dram_pin_pkg::COL_BITS-1:0]  col
	);
		return {ba, row_bit, col[dram_pin_pkg::COL_STORE_LO +: 2]};
	endfunction

	// ------------------------------------------------------------------
	// Command sampling and gating
	// ------------------------------------------------------------------
	dram_pin_pkg::pwr_t pwr_q;     // Power state
	dram_pin_pkg::pwr_t pwr_d;     // Next power state
	logic               sr_q;      // Self refresh held, cleared by enable
	dram_pin_pkg::cmd_t cmd;       // Decoded pins this edge
	logic               cmd_live;  // Commands accepted this edge
	logic [dram_pin_pkg::NUM_BANKS-1:0] row_open_q; // Bank has a row
	logic [dram_pin_pkg::NUM_BANKS-1:0] row_open_d;
	logic [dram_pin_pkg::NUM_BANKS-1:0] row_bit_q;  // Stored row bit
	logic               all_idle;  // No bank has a row open
	logic               take_act;
	logic               take_rd;
	logic               take_wr;
	logic               take_pre;
	logic               take_mrs;
	logic               sre_req;   // Refresh with enable low
	logic               ap_flag;   // Address ten
	logic [dram_pin_pkg::COL_BITS-1:0]  col;  // Column field
	logic [dram_pin_pkg::BASE_BITS-1:0] cmd_base;

	assign cmd      = decode_cmd(cmd_pins);
	// Command pins count only when fully awake; the termination pin counts in every power state
	assign cmd_live = (pwr_q == dram_pin_pkg::PWR_ON) && cke;
	assign take_act = cmd_live && (cmd == dram_pin_pkg::CMD_ACT);
	assign take_rd  = cmd_live && (cmd == dram_pin_pkg::CMD_RD);
	assign take_wr  = cmd_live && (cmd == dram_pin_pkg::CMD_WR);
	assign take_pre = cmd_live && (cmd == dram_pin_pkg::CMD_PRE);
	assign take_mrs = cmd_live && (cmd == dram_pin_pkg::CMD_MRS);
	assign all_idle = ~|row_open_q;
	assign sre_req  = (pwr_q == dram_pin_pkg::PWR_ON) && !cke
		&& (cmd == dram_pin_pkg::CMD_REF) && all_idle;
	assign ap_flag  = cmd_pins.addr[dram_pin_pkg::AP_BIT];
	assign col      = cmd_pins.addr[dram_pin_pkg::COL_BITS-1:0];
	assign cmd_base = store_base(cmd_pins.ba, row_bit_q[cmd_pins.ba],
		col);

	// ------------------------------------------------------------------
	// Power state
	// ------------------------------------------------------------------
	// Entry and power-down exit follow the clock-sampled enable
	always_comb begin
		pwr_d = pwr_q;
		case (pwr_q)
			dram_pin_pkg::PWR_ON: begin
				if (!cke) begin
					if (sre_req)
						pwr_d = dram_pin_pkg::PWR_SELF;
					else if (all_idle)
						pwr_d = dram_pin_pkg::PWR_PRE_PD;
					else
						pwr_d = dram_pin_pkg::PWR_ACT_PD;
				end
			end
			dram_pin_pkg::PWR_PRE_PD, dram_pin_pkg::PWR_ACT_PD: begin
				if (cke)
					pwr_d = dram_pin_pkg::PWR_ON;
			end
			// Only the held flag releases us; the state still waits for the next clock rise
			dram_pin_pkg::PWR_SELF: begin
				if (!sr_q)
					pwr_d = dram_pin_pkg::PWR_ON;
			end
			default: pwr_d = dram_pin_pkg::PWR_ON;
		endcase
	end

	// State register
	always_ff @(posedge ck) begin
		if (rst_link_q)
			pwr_q <= dram_pin_pkg::PWR_ON;
		else
			pwr_q <= pwr_d;
	end

	// Flag needs no clock edge: enable rising clears it at once; the state leaves at the next clock rise
	always_ff @(posedge ck or posedge cke) begin
		if (cke)
			sr_q <= 1'b0;
		else if (rst_link_q)
			sr_q <= 1'b0;
		else if (sre_req)
			sr_q <= 1'b1;
	end

	// ------------------------------------------------------------------
	// Bank state
	// ------------------------------------------------------------------
	// Open on activate, close on precharge or auto-precharge
	always_comb begin
		row_open_d = row_open_q;
		if (take_act)
			row_open_d[cmd_pins.ba] = 1'b1;
		if (take_pre && ap_flag)
			row_open_d = '0;
		else if (take_pre)
			row_open_d[cmd_pins.ba] = 1'b0;
		if ((take_rd || take_wr) && ap_flag)
			row_open_d[cmd_pins.ba] = 1'b0;
	end

	// Only the row's low bit is kept: the store aliases other rows
	always_ff @(posedge ck) begin
		if (rst_link_q) begin
			row_open_q <= '0;
			row_bit_q  <= '0;
		end else begin
			row_open_q <= row_open_d;
			if (take_act)
				row_bit_q[cmd_pins.ba] <= cmd_pins.addr[0];
		end
	end

	// ------------------------------------------------------------------
	// Mode registers and termination
	// ------------------------------------------------------------------
	// Bank bit zero steers the op-code to one of the two registers
	always_ff @(posedge ck) begin
		if (rst_link_q) begin
			mode_regs.mr  <= dram_pin_pkg::MR_RESET;
			mode_regs.emr <= dram_pin_pkg::EMR_RESET;
		end else if (take_mrs) begin
			if (cmd_pins.ba[dram_pin_pkg::MR_SEL_BIT])
				mode_regs.emr <= cmd_pins.addr;
			else
				mode_regs.mr  <= cmd_pins.addr;
		end
	end

	logic term_on_d;  // Pin high and mode allows it
	assign term_on_d = odt
		&& mode_regs.emr[dram_pin_pkg::EMR_ODT_EN_BIT];

	// Address and command pins never get termination
	always_ff @(posedge ck) begin
		if (rst_link_q)
			term_en <= '0;
		else
			term_en <= {4{term_on_d}};
	end

	// ------------------------------------------------------------------
	// Backing store
	// ------------------------------------------------------------------
	logic [dram_pin_pkg::DQ_BITS-1:0] mem_q [dram_pin_pkg::STORE_WORDS];

	// ------------------------------------------------------------------
	// Write capture on the strobes
	// ------------------------------------------------------------------
	logic [dram_pin_pkg::LANES-1:0] mask_pins; // Lower lane is bit 0
	logic [dram_pin_pkg::MASK_BIT:0] beat_cap
		[dram_pin_pkg::LANES][dram_pin_pkg::BURST_BEATS];

	assign mask_pins = {upper_byte_write_mask, lower_byte_write_mask};

	// Each strobe clocks its own byte and mask; the strobe sits
	// centred in the data, so both edges land mid-eye
	for (genvar l = 0; l < dram_pin_pkg::LANES; l++) begin : g_lane
		logic [dram_pin_pkg::MASK_BIT:0] rise_q [2]; // Beats 2, 0
		logic [dram_pin_pkg::MASK_BIT:0] fall_q [2]; // Beats 3, 1
		logic [dram_pin_pkg::MASK_BIT:0] beat_w;

		assign beat_w = {mask_pins[l],
			dq_i[l*dram_pin_pkg::BYTE_BITS +: dram_pin_pkg::BYTE_BITS]};

		// Rising strobe edge: even beats
		always_ff @(posedge byte_strobe_i[l]) begin
			rise_q[1] <= rise_q[0];
			rise_q[0] <= beat_w;
		end

		// Falling strobe edge: odd beats
		always_ff @(negedge byte_strobe_i[l]) begin
			fall_q[1] <= fall_q[0];
			fall_q[0] <= beat_w;
		end

		assign beat_cap[l][0] = rise_q[1];
		assign beat_cap[l][1] = fall_q[1];
		assign beat_cap[l][2] = rise_q[0];
		assign beat_cap[l][3] = fall_q[0];
	end

	// ------------------------------------------------------------------
	// Write commit
	// ------------------------------------------------------------------
	logic [dram_pin_pkg::WR_COMMIT_DLY-1:0] wr_pipe_q;
	logic [dram_pin_pkg::BASE_BITS-1:0] wr_base_q
		[dram_pin_pkg::WR_COMMIT_DLY];
	logic                               wr_commit;
	logic [dram_pin_pkg::BASE_BITS-1:0] wr_base;

	assign wr_commit = wr_pipe_q[dram_pin_pkg::WR_COMMIT_DLY-1];
	assign wr_base   = wr_base_q[dram_pin_pkg::WR_COMMIT_DLY-1];

	// Delay line from the write command to the commit edge
	always_ff @(posedge ck) begin
		if (rst_link_q)
			wr_pipe_q <= '0;
		else
			wr_pipe_q <= {wr_pipe_q[dram_pin_pkg::WR_COMMIT_DLY-2:0],
				take_wr};
		wr_base_q[0] <= cmd_base;
		for (int i = 1; i < dram_pin_pkg::WR_COMMIT_DLY; i++)
			wr_base_q[i] <= wr_base_q[i-1];
	end

	// Strobe-domain beats have been still for a full cycle by now,
	// which is what makes this source-synchronous handover safe
	always_ff @(posedge ck) begin
		if (wr_commit) begin
			for (int b = 0; b < dram_pin_pkg::BURST_BEATS; b++) begin
				for (int l = 0; l < dram_pin_pkg::LANES; l++) begin
					if (!beat_cap[l][b][dram_pin_pkg::MASK_BIT])
						mem_q[{wr_base, b[1:0]}]
							[l*dram_pin_pkg::BYTE_BITS +:
							dram_pin_pkg::BYTE_BITS] <=
							beat_cap[l][b][dram_pin_pkg::BYTE_BITS-1:0];
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	logic [dram_pin_pkg::READ_LATENCY-1:0] rd_pipe_q;
	logic [dram_pin_pkg::BASE_BITS-1:0] rd_base_pipe_q
		[dram_pin_pkg::READ_LATENCY];
	logic                               rd_start;
	logic [dram_pin_pkg::BASE_BITS-1:0] rd_start_base;
	logic [dram_pin_pkg::BASE_BITS-1:0] rd_base_q;  // Burst in flight
	logic                               rd_oe_q;    // Driving the bus
	logic                               rd_second_q;// Second pair due
	logic [dram_pin_pkg::DQ_BITS-1:0]   rise_q;     // High-phase beat
	logic [dram_pin_pkg::DQ_BITS-1:0]   fall_next_q;// Next low beat
	logic [dram_pin_pkg::DQ_BITS-1:0]   fall_q;     // Low-phase beat

	assign rd_start      = rd_pipe_q[dram_pin_pkg::READ_LATENCY-1];
	assign rd_start_base = rd_base_pipe_q[dram_pin_pkg::READ_LATENCY-1];

	// Latency line from the read command to the first beat
	always_ff @(posedge ck) begin
		if (rst_link_q)
			rd_pipe_q <= '0;
		else
			rd_pipe_q <= {rd_pipe_q[dram_pin_pkg::READ_LATENCY-2:0],
				take_rd};
		rd_base_pipe_q[0] <= cmd_base;
		for (int i = 1; i < dram_pin_pkg::READ_LATENCY; i++)
			rd_base_pipe_q[i] <= rd_base_pipe_q[i-1];
	end

	// Two cycles of two beats; a new start wins over a finishing pair.
	// Assumes enable stays high until the burst is out.
	always_ff @(posedge ck) begin
		if (rst_link_q) begin
			rd_oe_q     <= 1'b0;
			rd_second_q <= 1'b0;
			rd_base_q   <= '0;
			rise_q      <= '0;
			fall_next_q <= '0;
		end else if (rd_start) begin
			rd_oe_q     <= 1'b1;
			rd_second_q <= 1'b1;
			rd_base_q   <= rd_start_base;
			rise_q      <= mem_q[{rd_start_base, 2'h0}];
			fall_next_q <= mem_q[{rd_start_base, 2'h1}];
		end else if (rd_second_q) begin
			rd_second_q <= 1'b0;
			rise_q      <= mem_q[{rd_base_q, 2'h2}];
			fall_next_q <= mem_q[{rd_base_q, 2'h3}];
		end else begin
			rd_oe_q     <= 1'b0;
		end
	end

	// Falling edge half of each data cycle
	always_ff @(negedge ck) begin
		if (rst_link_q)
			fall_q <= '0;
		else
			fall_q <= fall_next_q;
	end

	// Both halves from flops; the clock level picks the half
	assign dq_o  = ck ? rise_q : fall_q;
	assign dq_oe = rd_oe_q;

	// Strobe follows the clock, so its edges meet the data edges
	assign byte_strobe_o    = {dram_pin_pkg::LANES{ck & rd_oe_q}};
	assign byte_strobe_oe   = {dram_pin_pkg::LANES{rd_oe_q}};
	assign byte_strobe_n_o  = ~byte_strobe_o;
	// One mode bit silences every complementary strobe together
	assign byte_strobe_n_oe = {dram_pin_pkg::LANES{rd_oe_q &&
		!mode_regs.emr[dram_pin_pkg::EMR_STRB_N_DIS]}};

	// ------------------------------------------------------------------
	// Status toward the system clock
	// ------------------------------------------------------------------
	dram_pin_pkg::status_t link_status_q; // Link-side levels
	dram_pin_pkg::status_t status_meta_q; // First stage only

	// Separate level bits, so each may cross on its own
	always_ff @(posedge ck) begin
		if (rst_link_q) begin
			link_status_q <= '0;
		end else begin
			link_status_q.power_down     <=
				(pwr_d == dram_pin_pkg::PWR_PRE_PD) ||
				(pwr_d == dram_pin_pkg::PWR_ACT_PD);
			link_status_q.self_refresh   <=
				(pwr_d == dram_pin_pkg::PWR_SELF);
			link_status_q.termination_on <= term_on_d;
			link_status_q.bank_open      <= |row_open_d;
		end
	end

	// Two-stage synchroniser per bit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_meta_q <= '0;
			status        <= '0;
		end else begin
			status_meta_q <= link_status_q;
			status        <= status_meta_q;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	localparam int RD_DLY = dram_pin_pkg::READ_LATENCY + 1;
	logic [dram_pin_pkg::WORD_BITS-1:0] wr_word0;
	logic [dram_pin_pkg::BYTE_BITS-1:0] lane0_old;
	assign wr_word0  = {wr_base, 2'h0};
	assign lane0_old = mem_q[wr_word0][dram_pin_pkg::BYTE_BITS-1:0];

	sequence rd_burst_s;
		rd_oe_q [*2] ##1 !rd_oe_q;
	endsequence

	deselect_masked_a: assert property (@(posedge ck)
		disable iff (rst_link_q)
		(cmd_live && cmd_pins.cs_n) |=> $stable(row_open_q))
		else $error("deselected command changed bank state");
	asleep_ignores_a: assert property (@(posedge ck)
		disable iff (rst_link_q)
		(pwr_q != dram_pin_pkg::PWR_ON) |=> $stable(row_open_q))
		else $error("command taken while not active");
	act_opens_bank_a: assert property (@(posedge ck)
		disable iff (rst_link_q)
		take_act |=> row_open_q[$past(cmd_pins.ba)])
		else $error("activate did not open the bank");
	pre_all_banks_a: assert property (@(posedge ck)
		disable iff (rst_link_q)
		(take_pre && ap_flag) |=> (row_open_q == '0))
		else $error("precharge all left a bank open");
	mode_select_a: assert property (@(posedge ck)
		disable iff (rst_link_q)
		(take_mrs && cmd_pins.ba[0]) |=>
		(mode_regs.emr == $past(cmd_pins.addr)) && $stable(mode_regs.mr))
		else $error("mode register select wrong");
	odt_ignored_a: assert property (@(posedge ck)
		disable iff (rst_link_q)
		!mode_regs.emr[dram_pin_pkg::EMR_ODT_EN_BIT] |=> !term_en.dq)
		else $error("termination on while disabled");
	odt_enable_a: assert property (@(posedge ck)
		disable iff (rst_link_q)
		(odt && mode_regs.emr[dram_pin_pkg::EMR_ODT_EN_BIT]) |=>
		(term_en == 4'hF))
		else $error("termination not switched on");
	act_pd_entry_a: assert property (@(posedge ck)
		disable iff (rst_link_q)
		((pwr_q == dram_pin_pkg::PWR_ON) && !cke && !all_idle) |=>
		(pwr_q == dram_pin_pkg::PWR_ACT_PD))
		else $error("active power-down not entered");
	self_ref_entry_a: assert property (@(posedge ck)
		disable iff (rst_link_q)
		sre_req |=> (pwr_q == dram_pin_pkg::PWR_SELF) && sr_q)
		else $error("self refresh not entered");
	read_burst_a: assert property (@(posedge ck)
		disable iff (rst_link_q)
		(take_rd ##1 !take_rd [*2]) |-> ##(RD_DLY - 2) rd_burst_s)
		else $error("read burst timing wrong");
	masked_byte_a: assert property (@(posedge ck)
		disable iff (rst_link_q)
		(wr_commit && beat_cap[0][0][dram_pin_pkg::MASK_BIT]) |=>
		(mem_q[$past(wr_word0)][dram_pin_pkg::BYTE_BITS-1:0] ==
		$past(lane0_old)))
		else $error("masked byte was written");
	self_ref_exit_a: assert property (@(posedge ck)
		disable iff (rst_link_q)
		((pwr_q == dram_pin_pkg::PWR_SELF) && cke) |=>
		(pwr_q == dram_pin_pkg::PWR_ON))
		else $error("self refresh exit missed");

endmodule

/* dram_pin_pkg.sv */
// ----------------------------------------------------------------------
// Shared constants and types for the DRAM pin-side device logic
// ----------------------------------------------------------------------
package dram_pin_pkg;

	// ------------------------------------------------------------------
	// Array geometry
	// ------------------------------------------------------------------
	localparam int ROW_BITS   = 13;  // Row address width
	localparam int COL_BITS   = 9;   // Column address width
	localparam int BANK_BITS  = 2;   // Bank address width
	localparam int ADDR_BITS  = 13;  // Multiplexed address pins
	localparam int DQ_BITS    = 16;  // Data pins
	localparam int BYTE_BITS  = 8;   // Bits per byte lane
	localparam int LANES      = 2;   // Byte lanes, lower first
	localparam int NUM_BANKS  = 4;   // Banks behind the bank inputs

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int AP_BIT          = 10; // Auto/all precharge flag
	localparam int MR_SEL_BIT      = 0;  // Bank bit picking the register
	localparam int EMR_ODT_EN_BIT  = 2;  // Termination enable
	localparam int EMR_STRB_N_DIS  = 10; // Complementary strobes off
	localparam int COL_STORE_LO    = 2;  // Lowest column bit stored
	localparam int MASK_BIT        = 8;  // Mask flag in a captured beat

	// ------------------------------------------------------------------
	// Burst length in beats, latency counts in link clock cycles
	// ------------------------------------------------------------------
	localparam int BURST_BEATS    = 4;
	localparam int READ_LATENCY   = 3;
	localparam int WRITE_LATENCY  = READ_LATENCY - 1;
	localparam int WR_COMMIT_DLY  = WRITE_LATENCY + 3;

	// ------------------------------------------------------------------
	// Small backing store: bank, row bit, column group, beat
	// ------------------------------------------------------------------
	localparam int BASE_BITS   = 5;
	localparam int WORD_BITS   = 7;
	localparam int STORE_WORDS = 128;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [ADDR_BITS-1:0] MR_RESET  = 13'h0000;
	localparam logic [ADDR_BITS-1:0] EMR_RESET = 13'h0000;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	// Command code is the select/row/column/write pattern itself
	typedef enum logic [3:0] {
		CMD_MRS   = 4'h0,
		CMD_REF   = 4'h1,
		CMD_PRE   = 4'h2,
		CMD_ACT   = 4'h3,
		CMD_WR    = 4'h4,
		CMD_RD    = 4'h5,
		CMD_NOP   = 4'h7,
		CMD_DESEL = 4'h8
	} cmd_t;

	// Power states, Gray steps between the active state and either power-down; self refresh flips both bits
	typedef enum logic [1:0] {
		PWR_ON     = 2'h0,
		PWR_PRE_PD = 2'h1,
		PWR_SELF   = 2'h3,
		PWR_ACT_PD = 2'h2
	} pwr_t;

	typedef struct packed {
		logic                 cs_n;
		logic                 ras_n;
		logic                 cas_n;
		logic                 we_n;
		logic [BANK_BITS-1:0] ba;
		logic [ADDR_BITS-1:0] addr;
	} cmd_pins_t;

	typedef struct packed {
		logic dq;
		logic strobe;
		logic strobe_n;
		logic mask;
	} term_t;

	typedef struct packed {
		logic [ADDR_BITS-1:0] mr;
		logic [ADDR_BITS-1:0] emr;
	} mode_regs_t;

	typedef struct packed {
		logic power_down;
		logic self_refresh;
		logic termination_on;
		logic bank_open;
	} status_t;

endpackage

/* ctl_model.sv */
`timescale 1ns/1ps
// Controller model: free-running clock, commands and write bursts
module ctl_model (
	output logic                    ck = 1'b0,
	output logic                    cke = 1'b1,
	output dram_pin_pkg::cmd_pins_t cmd_pins = {4'h7, 15'h0000},
	output logic [15:0]             dq = 16'h0000,
	output logic                    strb = 1'b0,
	output logic [1:0]              dm = 2'h0
);
	// Runs free, because the device needs it through reset
	always #62.5 ck = ~ck;
	// Command and enable on one edge, then a no-op
	task cmd(logic [3:0] c, logic [1:0] b, logic [12:0] a, logic k);
		@(posedge ck) #2;
		cmd_pins = {c, b, a};
		cke = k;
		@(posedge ck) #2;
		cmd_pins = {4'h7, b, a};
	endtask
	// Beats start two edges after the command
	task wr(logic [15:0] d, logic [1:0] m);
		cmd(4'h4, 2'h2, 13'h0004, 1'b1);
		repeat (2) @(posedge ck) #2;
		dm = m;
		for (int i = 0; i < 4; i++) begin
			dq = d + {i[7:0], i[7:0]};
			#31.25 strb = ~strb;
			#31.25;
		end
		dq = ~dq; // Released bus must not keep the last beat
	endtask
endmodule

/* tb_graphics_dram_pin_interface.sv */
`timescale 1ns/1ps
module tb_graphics_dram_pin_interface;
	logic clk = 1'b0, sys_rst = 1'b1, odt = 1'b1, ck, cke, strb, dq_oe;
	logic [15:0] dq_i, dq_o;
	logic [1:0] dm, so, snoe, soe, sno;
	dram_pin_pkg::cmd_pins_t cmd_pins;
	dram_pin_pkg::term_t term_en;
	dram_pin_pkg::mode_regs_t mode_regs;
	dram_pin_pkg::status_t status;
	int n_errors = 0, check_count = 0;
	always #2 clk = ~clk;
	ctl_model u_ctl (.ck(ck), .cke(cke), .cmd_pins(cmd_pins), .dq(dq_i),
		.strb(strb), .dm(dm));
	graphics_dram_pin_interface u_dut (.clk(clk), .sys_rst(sys_rst),
		.ck(ck), .cke(cke), .cmd_pins(cmd_pins), .odt(odt), .dq_i(dq_i),
		.dq_o(dq_o), .dq_oe(dq_oe), .byte_strobe_i({2{strb}}),
		.byte_strobe_n_i({2{~strb}}), .byte_strobe_o(so), .byte_strobe_oe(soe),
		.byte_strobe_n_o(sno), .byte_strobe_n_oe(snoe), .term_en(term_en),
		.lower_byte_write_mask(dm[0]), .upper_byte_write_mask(dm[1]),
		.mode_regs(mode_regs), .status(status));
	task chk(input logic ok);
		check_count++;
		if (ok !== 1'b1) n_errors++;
		if (ok !== 1'b1) $display("Error at %0t: mismatch", $time);
	endtask
	task finish_test();
		if (n_errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Settle inside the high phase of the link clock
	task wait_ck(input int n);
		repeat (n) @(posedge ck);
		#20;
	endtask
	// Mode writes gate termination; a deselected write is dropped
	task t_mode();
		u_ctl.cmd(4'h0, 2'h1, 13'h0404, 1'b1);
		wait_ck(2);
		chk(mode_regs.emr === 13'h0404 && term_en === 4'hF
			&& status.termination_on === 1'b1);
		// Termination pin low with the mode allowing it: all off
		@(posedge ck) #2 odt = 1'b0;
		wait_ck(2);
		chk(term_en === 4'h0 && status.termination_on === 1'b0);
		@(posedge ck) #2 odt = 1'b1;
		u_ctl.cmd(4'h0, 2'h1, 13'h0400, 1'b1);
		u_ctl.cmd(4'h8, 2'h0, 13'h1FFF, 1'b1);
		wait_ck(1);
		chk(term_en === 4'h0 && mode_regs.mr === 13'h0000);
	endtask
	// One read burst; n_oe is the expected complementary strobe enable
	task rd_chk(input logic [1:0] n_oe);
		u_ctl.cmd(4'h5, 2'h2, 13'h0004, 1'b1);
		wait_ck(3);
		for (int i = 0; i < 4; i++) begin
			chk(dq_oe === 1'b1 && dq_o === 16'h5030 + {i[7:0], i[7:0]});
			chk(so === {2{ck}} && soe === 2'h3 && sno === ~so
				&& snoe === n_oe);
			#62.5;
		end
		chk(dq_oe === 1'b0 && soe === 2'h0);
	endtask
	// Masked lower lane keeps old bytes; read on both phases
	task t_rw();
		u_ctl.cmd(4'h3, 2'h2, 13'h0000, 1'b1);
		u_ctl.wr(16'hC030, 2'h0);
		u_ctl.wr(16'h50E0, 2'h1);
		rd_chk(2'h0);
		u_ctl.cmd(4'h0, 2'h1, 13'h0000, 1'b1);
		rd_chk(2'h3);
	endtask
	// Power-down ignores commands; refresh with enable low
	task t_power();
		u_ctl.cmd(4'h7, 2'h0, 13'h0000, 1'b0);
		u_ctl.cmd(4'h0, 2'h0, 13'h0123, 1'b0);
		wait_ck(1);
		chk(status.power_down === 1'b1 && mode_regs.mr === 13'h0000);
		u_ctl.cmd(4'h7, 2'h0, 13'h0000, 1'b1);
		u_ctl.cmd(4'h2, 2'h0, 13'h0400, 1'b1);
		u_ctl.cmd(4'h1, 2'h0, 13'h0000, 1'b0);
		wait_ck(1);
		chk(status.self_refresh === 1'b1 && status.bank_open === 1'b0);
		// Flag clears at once; the state follows at the next link rise
		@(posedge ck) #2 u_ctl.cke = 1'b1;
		wait_ck(1);
		chk(status.self_refresh === 1'b0
			&& status.power_down === 1'b0);
	endtask
	initial begin
		repeat (8) @(posedge ck);
		#2 sys_rst = 1'b0;
		repeat (4) @(posedge ck);
		t_mode();
		t_rw();
		t_power();
		finish_test();
	end
	// The tests need under 10 us
	initial begin
		#60000 n_errors++;
		finish_test();
	end
endmodule
